//--- design/ltod_decoder.sv
/*
 * Literal and table-operation decode/execute stage of an 8-bit core.
 * Holds working register, status flags, bank select, product, pointers
 * and table pointer, all reachable over APB. Assumes the fetch stage
 * presents words with instr_valid and takes instr_ready as its advance.
 */
// The placing of the registers and the APB slave port were chosen for this implementation.
// Overview of operation
// - add literal to working register, all arithmetic flags
// - and literal into working register, zero/negative
// - or literal into working register, zero/negative
// - xor literal into working register, zero/negative
// - literal minus working register, all arithmetic flags
// - load literal into working register, no flags
// - load four bits into bank select
// - multiply literal by working register, no flags
// - load literal and return, two cycles
// - two-word 12-bit pointer load, two cycles
// - table read with four pointer modes
// - table write with four pointer modes
// - launched memory write persists until terminated
// - port self-modify reads pins, not latch
// - timer register modify clears assigned prescaler
// - program counter change costs one nop cycle
// - lone second word executes as nop
`timescale 1ns/1ps
module ltod_decoder #(
    parameter logic [7:0] PORT_ADDR = ltod_pkg::PORT_ADDR_DEF,
    parameter logic [7:0] TIMER_ADDR = ltod_pkg::TIMER_ADDR_DEF
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    output logic instr_ready,
    input wire logic [7:0] port_pins,
    input wire logic [7:0] port_latch,
    input wire logic mem_write_done,
    output logic mem_write_busy,
    output logic return_pop,
    output ltod_pkg::ltod_table_req_t table_req,
    output ltod_pkg::ltod_file_req_t file_req
);
    import ltod_pkg::*;

    ltod_state_t state;
    logic [7:0] working_register;
    logic [STATUS_W-1:0] status;
    logic [3:0] bank_select_register;
    logic [15:0] product;
    logic [TBLPTR_W-1:0] table_pointer;
    logic [PTR_W-1:0] file_select_pointer [PTR_N];
    logic [CTRL_W-1:0] ctrl;
    logic [1:0] ptr_sel;
    logic [3:0] ptr_hi;

    function automatic ltod_alu_t ltod_add(input logic [7:0] a, input logic [7:0] b, input logic cin);
        logic [4:0] lo;
        logic [8:0] full;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        ltod_add.res = full[7:0];
        ltod_add.c = full[8];
        ltod_add.dc = lo[4];
        ltod_add.ov = (a[7] == b[7]) && (full[7] != a[7]);
    endfunction

    function automatic logic [STATUS_W-1:0] ltod_zn(input logic [STATUS_W-1:0] s, input logic [7:0] r);
        logic [STATUS_W-1:0] t;
        t = s;
        t[ST_Z] = (r == 8'h00);
        t[ST_N] = r[7];
        return t;
    endfunction

    function automatic logic [STATUS_W-1:0] ltod_arith(input logic [STATUS_W-1:0] s, input ltod_alu_t a);
        logic [STATUS_W-1:0] t;
        t = ltod_zn(s, a.res);
        t[ST_C] = a.c;
        t[ST_DC] = a.dc;
        t[ST_OV] = a.ov;
        return t;
    endfunction

    // decode
    logic accept;
    logic exec;
    logic [7:0] op_hi;
    logic [7:0] lit;
    logic [3:0] grp;
    logic is_bank;
    logic is_tbl;
    logic is_ptr1;
    logic modifies_file;
    ltod_alu_t add_r;
    ltod_alu_t sub_r;
    logic apb_wr;
    logic apb_setup;

    assign accept = instr_valid && instr_ready;
    assign exec = accept && (state == ST_EXEC);
    assign op_hi = instr_word[15:8];
    assign lit = instr_word[7:0];
    assign grp = instr_word[15:12];
    assign is_bank = (instr_word[15:4] == OPC_BANK);
    assign is_tbl = (instr_word[15:4] == OPC_TBL) && instr_word[TBL_GROUP_BIT];
    assign is_ptr1 = (op_hi == OPC_PTR1) && (instr_word[7:6] == 2'b00);
    // byte ops with d=1, or bit set/clear/toggle, write back to the file
    assign modifies_file = ((grp >= 4'h1) && (grp <= 4'h5) && instr_word[DEST_BIT])
        || (grp == 4'h7) || (grp == 4'h8) || (grp == 4'h9);
    assign add_r = ltod_add(working_register, lit, 1'b0);
    assign sub_r = ltod_add(lit, ~working_register, 1'b1);
    assign apb_wr = psel && penable && pready && pwrite;
    assign apb_setup = psel && !penable;

    // sequencing
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state <= ST_EXEC;
            instr_ready <= 1'b1;
        end
        else
        begin
            case (state)
                ST_EXEC:
                begin
                    if (exec && (op_hi == OPC_RETV || is_tbl))
                    begin
                        state <= ST_NOP;
                        instr_ready <= 1'b0;
                    end
                    else if (exec && is_ptr1)
                    begin
                        state <= ST_OPERAND;
                    end
                end
                ST_OPERAND:
                begin
                    if (accept)
                    begin
                        state <= ST_EXEC;
                    end
                end
                ST_NOP:
                begin
                    state <= ST_EXEC;
                    instr_ready <= 1'b1;
                end
                default:
                begin
                    state <= ST_EXEC;
                    instr_ready <= 1'b1;
                end
            endcase
        end
    end

    // working register; an instruction beats a same-cycle APB write
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            working_register <= 8'h00;
        end
        else if (exec && op_hi == OPC_ADD)
        begin
            working_register <= add_r.res;
        end
        else if (exec && op_hi == OPC_AND)
        begin
            working_register <= working_register & lit;
        end
        else if (exec && op_hi == OPC_OR)
        begin
            working_register <= working_register | lit;
        end
        else if (exec && op_hi == OPC_XOR)
        begin
            working_register <= working_register ^ lit;
        end
        else if (exec && op_hi == OPC_RSUB)
        begin
            working_register <= sub_r.res;
        end
        else if (exec && (op_hi == OPC_LOAD || op_hi == OPC_RETV))
        begin
            working_register <= lit;
        end
        else if (apb_wr && paddr == OFS_WORKING_REGISTER)
        begin
            working_register <= pwdata[7:0];
        end
    end

    // status flags
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            status <= '0;
        end
        else if (exec && op_hi == OPC_ADD)
        begin
            status <= ltod_arith(status, add_r);
        end
        else if (exec && op_hi == OPC_RSUB)
        begin
            status <= ltod_arith(status, sub_r);
        end
        else if (exec && op_hi == OPC_AND)
        begin
            status <= ltod_zn(status, working_register & lit);
        end
        else if (exec && op_hi == OPC_OR)
        begin
            status <= ltod_zn(status, working_register | lit);
        end
        else if (exec && op_hi == OPC_XOR)
        begin
            status <= ltod_zn(status, working_register ^ lit);
        end
        else if (apb_wr && paddr == OFS_STATUS)
        begin
            status <= pwdata[STATUS_W-1:0];
        end
    end

    // bank select and product
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            bank_select_register <= 4'h0;
        end
        else if (exec && is_bank)
        begin
            bank_select_register <= instr_word[3:0];
        end
        else if (apb_wr && paddr == OFS_BANK)
        begin
            bank_select_register <= pwdata[3:0];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            product <= 16'h0000;
        end
        else if (exec && op_hi == OPC_MUL)
        begin
            product <= 16'(working_register) * 16'(lit);
        end
    end

    // pointer load: first word latches select and high nibble
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ptr_sel <= 2'h0;
            ptr_hi <= 4'h0;
        end
        else if (exec && is_ptr1)
        begin
            ptr_sel <= instr_word[5:4];
            ptr_hi <= instr_word[3:0];
        end
    end

    // select 3 has no pointer behind it and is dropped
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < PTR_N; i++)
            begin
                file_select_pointer[i] <= '0;
            end
        end
        else if (accept && state == ST_OPERAND && op_hi == OPC_PTR2 && ptr_sel < 2'(PTR_N))
        begin
            file_select_pointer[ptr_sel] <= {ptr_hi, lit};
        end
        else if (apb_wr)
        begin
            for (int i = 0; i < PTR_N; i++)
            begin
                if (paddr == OFS_PTR0 + 8'(4 * i))
                begin
                    file_select_pointer[i] <= pwdata[PTR_W-1:0];
                end
            end
        end
    end

    // table pointer and requests
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            table_pointer <= '0;
            table_req <= '0;
        end
        else
        begin
            table_req.valid <= exec && is_tbl;
            table_req.write <= instr_word[TBL_WRITE_BIT];
            table_req.addr <= (instr_word[1:0] == TBL_PREINC) ? table_pointer + 21'h1 : table_pointer;
            if (exec && is_tbl)
            begin
                case (instr_word[1:0])
                    TBL_NONE: table_pointer <= table_pointer;
                    TBL_POSTINC: table_pointer <= table_pointer + 21'h1;
                    TBL_POSTDEC: table_pointer <= table_pointer - 21'h1;
                    TBL_PREINC: table_pointer <= table_pointer + 21'h1;
                    default: table_pointer <= table_pointer;
                endcase
            end
            else if (apb_wr && paddr == OFS_TBLPTR)
            begin
                table_pointer <= pwdata[TBLPTR_W-1:0];
            end
        end
    end

    // a launched write outlives its instruction; a new launch wins over done
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            mem_write_busy <= 1'b0;
        end
        else if (exec && is_tbl && instr_word[TBL_WRITE_BIT] && ctrl[CTRL_WRITE_LAUNCH])
        begin
            mem_write_busy <= 1'b1;
        end
        else if (mem_write_done)
        begin
            mem_write_busy <= 1'b0;
        end
    end

    // return request
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            return_pop <= 1'b0;
        end
        else
        begin
            return_pop <= exec && op_hi == OPC_RETV;
        end
    end

    // file write-back requests; a lone second word reaches none of these
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            file_req <= '0;
        end
        else
        begin
            file_req.valid <= exec && modifies_file && grp != OPC_SECOND;
            file_req.addr <= lit;
            file_req.src <= (lit == PORT_ADDR) ? port_pins : port_latch;
            file_req.prescaler_clr <= exec && modifies_file && lit == TIMER_ADDR
                && ctrl[CTRL_PRESCALER_ASSIGNED];
        end
    end

    // control
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ctrl <= '0;
        end
        else if (apb_wr && paddr == OFS_CTRL)
        begin
            ctrl <= pwdata[CTRL_W-1:0];
        end
    end

    // APB: one wait-free access phase, answer registered in setup
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= apb_setup;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (apb_setup)
            begin
                case (paddr)
                    OFS_CTRL: prdata <= 32'(ctrl);
                    OFS_WORKING_REGISTER: prdata <= 32'(working_register);
                    OFS_STATUS: prdata <= 32'(status);
                    OFS_BANK: prdata <= 32'(bank_select_register);
                    OFS_PROD: prdata <= 32'(product);
                    OFS_TBLPTR: prdata <= 32'(table_pointer);
                    OFS_PTR0: prdata <= 32'(file_select_pointer[0]);
                    OFS_PTR0 + 8'h04: prdata <= 32'(file_select_pointer[1]);
                    OFS_PTR0 + 8'h08: prdata <= 32'(file_select_pointer[2]);
                    OFS_MEMSTAT: prdata <= 32'(mem_write_busy);
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule

//--- design/ltod_pkg.sv
/*
 * Shared constants and types for the literal and table operation decoder.
 * Assumes a single 10 MHz core clock and an APB master for register access.
 */
package ltod_pkg;
    // literal group, upper opcode byte
    localparam logic [7:0] OPC_ADD = 8'h0F;
    localparam logic [7:0] OPC_AND = 8'h0B;
    localparam logic [7:0] OPC_OR = 8'h09;
    localparam logic [7:0] OPC_XOR = 8'h0A;
    localparam logic [7:0] OPC_RSUB = 8'h08;
    localparam logic [7:0] OPC_LOAD = 8'h0E;
    localparam logic [7:0] OPC_MUL = 8'h0D;
    localparam logic [7:0] OPC_RETV = 8'h0C;
    localparam logic [11:0] OPC_BANK = 12'h010;
    localparam logic [7:0] OPC_PTR1 = 8'hEE;
    localparam logic [7:0] OPC_PTR2 = 8'hF0;
    localparam logic [3:0] OPC_SECOND = 4'hF;
    localparam logic [11:0] OPC_TBL = 12'h000;
    localparam int TBL_GROUP_BIT = 3;
    localparam int TBL_WRITE_BIT = 2;
    localparam int DEST_BIT = 9;
    // table pointer adjustment, low two opcode bits
    localparam logic [1:0] TBL_NONE = 2'h0;
    localparam logic [1:0] TBL_POSTINC = 2'h1;
    localparam logic [1:0] TBL_POSTDEC = 2'h2;
    localparam logic [1:0] TBL_PREINC = 2'h3;
    // status bit positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_N = 4;
    localparam int STATUS_W = 5;
    localparam int PTR_W = 12;
    localparam int PTR_N = 3;
    localparam int TBLPTR_W = 21;
    // APB byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WORKING_REGISTER = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_BANK = 8'h0C;
    localparam logic [7:0] OFS_PROD = 8'h10;
    localparam logic [7:0] OFS_TBLPTR = 8'h14;
    localparam logic [7:0] OFS_PTR0 = 8'h18;
    localparam logic [7:0] OFS_MEMSTAT = 8'h24;
    localparam int CTRL_PRESCALER_ASSIGNED = 0;
    localparam int CTRL_WRITE_LAUNCH = 1;
    localparam int CTRL_W = 2;
    localparam logic [7:0] PORT_ADDR_DEF = 8'h81;
    localparam logic [7:0] TIMER_ADDR_DEF = 8'hD6;

    typedef enum logic [2:0] {
        ST_EXEC = 3'b001,
        ST_OPERAND = 3'b010,
        ST_NOP = 3'b100
    } ltod_state_t;

    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic dc;
        logic ov;
    } ltod_alu_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [TBLPTR_W-1:0] addr;
    } ltod_table_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] src;
        logic prescaler_clr;
    } ltod_file_req_t;
endpackage

//--- verification/ltod_decoder_assertions.sv
/* Checker for the decoder's port behaviour.
   Assumes it is bound to ltod_decoder, one clock, synchronous reset. */
`timescale 1ns/1ps
module ltod_decoder_assertions #(
    parameter logic [7:0] PORT_ADDR = ltod_pkg::PORT_ADDR_DEF,
    parameter logic [7:0] TIMER_ADDR = ltod_pkg::TIMER_ADDR_DEF
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic instr_ready,
    input wire logic [7:0] port_pins,
    input wire logic [7:0] port_latch,
    input wire logic mem_write_done,
    input wire logic mem_write_busy,
    input wire logic return_pop,
    input wire ltod_pkg::ltod_table_req_t table_req,
    input wire ltod_pkg::ltod_file_req_t file_req
);
    import ltod_pkg::*;
    logic opnd;
    logic exec_w;
    logic file_op;
    // operand word of a pointer load is not an instruction of its own
    assign exec_w = instr_valid && instr_ready && !opnd;
    assign file_op = (instr_word[15:12] inside {[4'h1:4'h5]} && instr_word[DEST_BIT])
        || instr_word[15:12] inside {4'h7, 4'h8, 4'h9};
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            opnd <= 1'b0;
        else if (instr_valid && instr_ready)
            opnd <= !opnd && instr_word[15:8] == OPC_PTR1 && instr_word[7:6] == 2'b00;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_access: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("ready outside access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_ret_nop: assert property (exec_w && instr_word[15:8] == OPC_RETV
        |=> return_pop && !instr_ready ##1 instr_ready && !return_pop)
        else $error("return timing wrong");
    a_tbl_pulse: assert property (exec_w && instr_word[15:3] == {OPC_TBL, 1'b1}
        |=> table_req.valid && !instr_ready && table_req.write == $past(instr_word[TBL_WRITE_BIT]))
        else $error("table request wrong");
    a_tbl_cause: assert property (table_req.valid |-> $past(exec_w) && $past(instr_word[15:3]) == {OPC_TBL, 1'b1})
        else $error("table request without table op");
    a_port_src: assert property (exec_w && file_op |=> file_req.valid
        && file_req.src == ($past(instr_word[7:0]) == PORT_ADDR ? $past(port_pins) : $past(port_latch)))
        else $error("file source wrong");
    a_clr_timer: assert property (file_req.prescaler_clr |-> file_req.valid && file_req.addr == TIMER_ADDR)
        else $error("prescaler clear off timer");
    a_busy_holds: assert property (mem_write_busy && !mem_write_done |=> mem_write_busy)
        else $error("memory write ended early");
    a_lone_second: assert property (exec_w && instr_word[15:12] == OPC_SECOND
        |=> instr_ready && !table_req.valid && !file_req.valid && !return_pop)
        else $error("lone second word not a nop");
    c_ret: cover property (return_pop);
    c_tbl_wr: cover property (table_req.valid && table_req.write);
    c_clr: cover property (file_req.prescaler_clr);
endmodule

bind ltod_decoder ltod_decoder_assertions #(.PORT_ADDR(PORT_ADDR), .TIMER_ADDR(TIMER_ADDR)) ltod_decoder_assertions_i (
    .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .instr_valid,
    .instr_word, .instr_ready, .port_pins, .port_latch, .mem_write_done, .mem_write_busy, .return_pop,
    .table_req, .file_req);

//--- verification/ltod_decoder_tb.sv
/* Self-checking bench for ltod_decoder: APB tasks plus a fetch model.
   Assumes default port and timer addresses. */
`timescale 1ns/1ps
module ltod_decoder_tb;
    import ltod_pkg::*;
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] w;
        logic [7:0] k;
        logic [7:0] st0;
        logic [7:0] ofs;
        logic [15:0] exp;
        logic [7:0] st;
    } ltod_lit_t;
    typedef struct packed {
        logic [15:0] word;
        logic [1:0] ctrl;
        logic [7:0] src;
        logic clr;
    } ltod_file_t;
    logic clk_sys;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic instr_valid;
    logic [15:0] instr_word;
    logic instr_ready;
    logic [7:0] port_pins;
    logic [7:0] port_latch;
    logic mem_write_done;
    logic mem_write_busy;
    logic return_pop;
    logic slow;
    ltod_table_req_t table_req;
    ltod_file_req_t file_req;
    int n_mismatch;
    int cmp_count;
    logic [7:0] regs [7] = '{OFS_WORKING_REGISTER, OFS_STATUS, OFS_BANK, OFS_PROD, OFS_TBLPTR, OFS_PTR0, OFS_MEMSTAT};
    logic [31:0] tptr [4] = '{32'h100, 32'h101, 32'hFF, 32'h101};
    ltod_lit_t lit [11] = '{
        '{OPC_ADD, 8'h10, 8'h15, 8'h00, OFS_WORKING_REGISTER, 16'h25, 8'h00},
        '{OPC_ADD, 8'hFF, 8'h01, 8'h00, OFS_WORKING_REGISTER, 16'h00, 8'h07},
        '{OPC_ADD, 8'h7F, 8'h01, 8'h00, OFS_WORKING_REGISTER, 16'h80, 8'h1A},
        '{OPC_AND, 8'hF0, 8'h0F, 8'h0B, OFS_WORKING_REGISTER, 16'h00, 8'h0F},
        '{OPC_OR, 8'h80, 8'h01, 8'h0B, OFS_WORKING_REGISTER, 16'h81, 8'h1B},
        '{OPC_XOR, 8'h55, 8'h55, 8'h03, OFS_WORKING_REGISTER, 16'h00, 8'h07},
        '{OPC_RSUB, 8'h03, 8'h05, 8'h00, OFS_WORKING_REGISTER, 16'h02, 8'h03},
        '{OPC_RSUB, 8'h01, 8'h00, 8'h0F, OFS_WORKING_REGISTER, 16'hFF, 8'h10},
        '{OPC_LOAD, 8'h33, 8'h00, 8'h1F, OFS_WORKING_REGISTER, 16'h00, 8'h1F},
        '{OPC_MUL, 8'h10, 8'h20, 8'h1F, OFS_PROD, 16'h200, 8'h1F},
        '{OPC_RETV, 8'h00, 8'h42, 8'h15, OFS_WORKING_REGISTER, 16'h42, 8'h15}};
    ltod_file_t fops [4] = '{
        '{{8'h70, PORT_ADDR_DEF}, 2'h0, 8'h0F, 1'b0},
        '{16'h7022, 2'h0, 8'hF0, 1'b0},
        '{{8'h22, TIMER_ADDR_DEF}, 2'h1, 8'hF0, 1'b1},
        '{{8'h22, TIMER_ADDR_DEF}, 2'h0, 8'hF0, 1'b0}};

    always #50 clk_sys = ~clk_sys;

    ltod_decoder ltod_decoder_i (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .instr_valid, .instr_word, .instr_ready, .port_pins, .port_latch, .mem_write_done,
        .mem_write_busy, .return_pop, .table_req, .file_req);
    ltod_fetch_model ltod_fetch_model_i (.clk_sys, .rst_n, .slow, .instr_ready, .instr_valid, .instr_word);

    task results();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // no wait-state limit here; a hang is the watchdog's to catch
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask
    task push(input logic [15:0] w);
        @(negedge clk_sys);
        ltod_fetch_model_i.q.push_back(w);
    endtask
    task run(input logic [15:0] w);
        push(w);
        while (ltod_fetch_model_i.q.size() > 0 || instr_ready !== 1'b1)
        begin
            @(posedge clk_sys);
        end
        repeat (2) @(posedge clk_sys);
    endtask
    task wait_req(input logic tbl);
        while ((tbl ? table_req.valid : file_req.valid) !== 1'b1)
        begin
            @(negedge clk_sys);
        end
    endtask

    initial
    begin
        logic [31:0] rd;
        logic er;
        clk_sys = 1'b0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        port_pins = 8'h0F;
        port_latch = 8'hF0;
        mem_write_done = 1'b0;
        slow = 1'b0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (regs[i])
            rdc(regs[i], 32'h0);
        apb(1'b0, 8'h40, 32'h0, rd, er);
        chk({31'h0, er}, 32'h1);
        wr(OFS_PROD, 32'hFFFF);
        rdc(OFS_PROD, 32'h0);
        foreach (lit[i])
        begin
            wr(OFS_WORKING_REGISTER, 32'(lit[i].w));
            wr(OFS_STATUS, 32'(lit[i].st0));
            run({lit[i].op, lit[i].k});
            rdc(lit[i].ofs, 32'(lit[i].exp));
            rdc(OFS_STATUS, 32'(lit[i].st));
        end
        run({OPC_BANK, 4'hA});
        rdc(OFS_BANK, 32'hA);
        for (int f = 0; f < 3; f++)
        begin
            slow <= f[0];
            push({OPC_PTR1, 2'b00, f[1:0], 4'hA});
            run({OPC_PTR2, 8'h50 | 8'(f)});
            rdc(OFS_PTR0 + 8'(4 * f), 32'hA50 | 32'(f));
        end
        run(16'hF0FF);
        rdc(OFS_PTR0, 32'hA50);
        rdc(OFS_WORKING_REGISTER, 32'h42);
        wr(OFS_CTRL, 32'h2);
        for (int i = 0; i < 8; i++)
        begin
            wr(OFS_TBLPTR, 32'h100);
            push(16'h0008 + 16'(i));
            wait_req(1'b1);
            chk(32'({table_req.valid, table_req.write, table_req.addr}),
                {9'h0, 1'b1, i[2], (i[1:0] == TBL_PREINC) ? 21'h101 : 21'h100});
            repeat (2) @(posedge clk_sys);
            rdc(OFS_TBLPTR, tptr[i[1:0]]);
            if (i[2])
            begin
                rdc(OFS_MEMSTAT, 32'h1);
                repeat (4) @(posedge clk_sys);
                rdc(OFS_MEMSTAT, 32'h1);
                @(posedge clk_sys);
                mem_write_done <= 1'b1;
                @(posedge clk_sys);
                mem_write_done <= 1'b0;
                rdc(OFS_MEMSTAT, 32'h0);
            end
        end
        foreach (fops[i])
        begin
            wr(OFS_CTRL, 32'(fops[i].ctrl));
            push(fops[i].word);
            wait_req(1'b0);
            chk(32'({file_req.valid, file_req.addr, file_req.src, file_req.prescaler_clr}),
                32'({1'b1, fops[i].word[7:0], fops[i].src, fops[i].clr}));
            repeat (2) @(posedge clk_sys);
        end
        results();
    end

    initial
    begin
        // whole sequence needs well under a thousand cycles
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        results();
    end
endmodule

//--- verification/ltod_fetch_model.sv
/* Fetch stage model: presents queued words on the valid/ready handshake.
   Assumes the bench fills q away from the rising edge. */
`timescale 1ns/1ps
module ltod_fetch_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic instr_ready,
    output logic instr_valid,
    output logic [15:0] instr_word
);
    logic [15:0] q [$];
    logic gap;
    initial
    begin
        instr_valid = 1'b0;
        instr_word = 16'h0000;
    end
    always @(posedge clk_sys)
    begin
        if (instr_valid && instr_ready)
            q.delete(0);
        // slow mode leaves an idle cycle after every taken word
        gap = slow && instr_valid && instr_ready;
        if (rst_n && q.size() > 0 && !gap)
        begin
            instr_valid <= 1'b1;
            instr_word <= q[0];
        end
        else
        begin
            instr_valid <= 1'b0;
            // idle bus inverts the previous cycle's word each cycle
            instr_word <= ~instr_word;
        end
    end
endmodule
